// file: verilog/qdsc_pkg.sv
// Constants for the quad converter serial control block.
// Assumes nothing beyond a SystemVerilog compiler.
package qdsc_pkg;
    // Word layout
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int NUM_CH = 4;
    localparam int CNT_BITS = 5;
    localparam int ADDR_HI_POS = 15;
    localparam int ADDR_LO_POS = 14;
    localparam int PWR_POS = 13;
    localparam int SPD_POS = 12;
    localparam int CODE_MSB = 11;
    localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
    // Channel addresses
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;
    // Reset values
    localparam logic [CODE_BITS-1:0] CODE_RST = 12'h000;
    localparam logic SPD_RST = 1'b0;
    localparam logic PWR_RST = 1'b0;
    localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    // Clock cycles after reset before link flags are trusted
    localparam logic [1:0] SETTLE_CNT = 2'h3;
    // Synchroniser bit order and reset values
    localparam int SY_TGL = 0;
    localparam int SY_PART = 1;
    localparam int SY_FS = 2;
    localparam int SY_CS = 3;
    localparam int SY_LATCH_UPDATE_N = 4;
    localparam int SY_PD = 5;
    localparam int SY_W = 6;
    localparam logic [SY_W-1:0] SY_RST = 6'h3c;
endpackage : qdsc_pkg

// file: verilog/qdsc_sync.sv
// Two-flop level synchroniser, any width.
// Assumes each bit is an independent level or toggle.
`timescale 1ns/1ns
module qdsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : qdsc_sync

// file: verilog/qdsc_link_shift.sv
// Shift-clock side: serial word capture on the host's clock.
// Assumes the host holds frame_sync high between frames.
`timescale 1ns/1ns
module qdsc_link_shift
    import qdsc_pkg::*;
(
    // Link clock and reset synced to it
    input wire logic sclk,
    input wire logic link_rst,
    // Serial pins
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic sdin,
    // To the system domain
    output logic [WORD_BITS-1:0] shift_q,
    output logic [WORD_BITS-1:0] word_q,
    output logic word_tgl_q,
    output logic partial_q
);
    logic [CNT_BITS-1:0] cnt_q;
    logic fs_prev_q;
    logic done_q;

    // Falling edges: framing and shifting
    always_ff @(negedge sclk) begin
        if (link_rst) begin
            cnt_q <= CNT_ZERO;
            shift_q <= WORD_RST;
            fs_prev_q <= 1'b1;
            partial_q <= 1'b0;
        end else begin
            fs_prev_q <= frame_sync;
            if (!cs_n && !frame_sync) begin
                if (fs_prev_q) begin
                    shift_q <= {{(WORD_BITS-1){1'b0}}, sdin};
                    cnt_q <= CNT_ONE;
                    partial_q <= 1'b1;
                end else if (cnt_q != CNT_FULL) begin
                    shift_q <= {shift_q[WORD_BITS-2:0], sdin};
                    cnt_q <= cnt_q + CNT_ONE;
                    partial_q <= (cnt_q != CNT_FULL - CNT_ONE);
                end
            end
        end
    end

    // First rising edge after the sixteenth bit hands the word over
    always_ff @(posedge sclk) begin
        if (link_rst) begin
            done_q <= 1'b0;
            word_tgl_q <= 1'b0;
            word_q <= WORD_RST;
        end else if (cnt_q == CNT_FULL && !done_q) begin
            word_q <= shift_q;
            word_tgl_q <= ~word_tgl_q;
            done_q <= 1'b1;
        end else if (cnt_q != CNT_FULL) begin
            done_q <= 1'b0;
        end
    end
endmodule : qdsc_link_shift

// file: verilog/qdsc_serial_ctrl.sv
// Serial input and channel control of a four-channel 12-bit converter.
// Assumes sclk is unrelated to clk and may stop outside frames.
// Assumes latch_update_n is held low when outputs should follow words.
// What this block does
// - Frame sync fall starts a word, MSB first on shift clock falls.
// - After 16 bits or frame sync rise, the word loads its channel.
// - Works with select driven (four wire) or tied low (three wire).
// - Full word updates on the first rising clock after bit sixteen.
// - Reset clears all latch bits to zero without host action.
// - Top four bits are control, low twelve the new code.
// - Bit twelve: one selects fast settling, zero slow.
// - Bit thirteen: one powers down, zero normal operation.
// - Powered-down state disables the amplifiers.
// - Top two bits pick channel: 00 A, 01 B, 10 C, 11 D.
// - Code is unsigned, zero to 4095, output scaled by code/4096.
// - Hardware power-down input low disables all four amplifiers.
// - Latch-update low pulse moves stored values to all four outputs.
`timescale 1ns/1ns
module qdsc_serial_ctrl
    import qdsc_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link from the host
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic sdin,
    // Device control pins
    input wire logic latch_update_n,
    input wire logic hw_powerdown_n,
    // Channel A outputs
    output logic [CODE_BITS-1:0] code_a,
    output logic fast_a,
    output logic amp_en_a,
    // Channel B outputs
    output logic [CODE_BITS-1:0] code_b,
    output logic fast_b,
    output logic amp_en_b,
    // Channel C outputs
    output logic [CODE_BITS-1:0] code_c,
    output logic fast_c,
    output logic amp_en_c,
    // Channel D outputs
    output logic [CODE_BITS-1:0] code_d,
    output logic fast_d,
    output logic amp_en_d,
    // Status
    output logic update_pulse,
    output logic [1:0] update_chan,
    output logic short_frame,
    output logic [WORD_BITS-1:0] last_word,
    output logic [15:0] word_count
);
    // Link side signals
    logic link_rst;
    logic [WORD_BITS-1:0] link_shift;
    logic [WORD_BITS-1:0] link_word;
    logic link_tgl;
    logic link_part;

    // Synchronised pins and link flags
    logic [SY_W-1:0] sy_in;
    logic [SY_W-1:0] sy;

    // Edge history
    logic tgl_prev_q;
    logic fs_prev_q;
    logic cs_prev_n_q;
    logic latch_update_n_prev_q;

    // Events
    logic word_evt;
    logic early_evt;
    logic upd;
    logic latch_update_n_fall;
    logic [WORD_BITS-1:0] new_word;
    logic [1:0] new_chan;
    logic new_pwr;
    logic new_spd;
    logic [CODE_BITS-1:0] new_code;

    // Input latches written by words
    logic [CODE_BITS-1:0] in_code_q [NUM_CH];
    logic [NUM_CH-1:0] in_spd_q;
    logic [NUM_CH-1:0] in_pwr_q;

    // Output latches seen by the converters
    logic [CODE_BITS-1:0] out_code_q [NUM_CH];
    logic [NUM_CH-1:0] out_spd_q;
    logic [NUM_CH-1:0] out_pwr_q;
    logic [NUM_CH-1:0] out_pwr_d;
    logic [NUM_CH-1:0] load_now;

    // Registered amplifier enables
    logic [NUM_CH-1:0] amp_en_q;

    // Settling after reset
    logic [1:0] settle_q;
    logic settled;

    // Status registers
    logic update_pulse_q;
    logic [1:0] update_chan_q;
    logic short_frame_q;
    logic [WORD_BITS-1:0] last_word_q;
    logic [15:0] word_count_q;

    // Address match for one channel
    function automatic logic ch_hit(input logic [1:0] addr,
                                    input logic [1:0] ch);
        ch_hit = (addr == ch);
    endfunction : ch_hit

    // Amplifier enable from both power-down sources
    function automatic logic amp_on(input logic sw_pwr,
                                    input logic hw_pd_n);
        amp_on = hw_pd_n && !sw_pwr;
    endfunction : amp_on

    // Reset into the link domain; acts once sclk runs
    qdsc_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_link_rst (
        .clk(sclk),
        .rst(1'b0),
        .d(rst),
        .q(link_rst)
    );

    // Serial capture on the link clock
    qdsc_link_shift u_link (
        .sclk(sclk),
        .link_rst(link_rst),
        .cs_n(cs_n),
        .frame_sync(frame_sync),
        .sdin(sdin),
        .shift_q(link_shift),
        .word_q(link_word),
        .word_tgl_q(link_tgl),
        .partial_q(link_part)
    );

    // Pins and link flags into the system domain
    // Words cross as data held still while the toggle settles
    always_comb begin
        sy_in = '0;
        sy_in[SY_TGL] = link_tgl;
        sy_in[SY_PART] = link_part;
        sy_in[SY_FS] = frame_sync;
        sy_in[SY_CS] = cs_n;
        sy_in[SY_LATCH_UPDATE_N] = latch_update_n;
        sy_in[SY_PD] = hw_powerdown_n;
    end

    qdsc_sync #(
        .W(SY_W),
        .RST_VAL(SY_RST)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d(sy_in),
        .q(sy)
    );

    // Edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            tgl_prev_q <= 1'b0;
            fs_prev_q <= 1'b1;
            cs_prev_n_q <= 1'b1;
            latch_update_n_prev_q <= 1'b1;
        end else begin
            tgl_prev_q <= sy[SY_TGL];
            fs_prev_q <= sy[SY_FS];
            cs_prev_n_q <= sy[SY_CS];
            latch_update_n_prev_q <= sy[SY_LATCH_UPDATE_N];
        end
    end

    // Link flags are ignored until the synchroniser shows real values,
    // so a toggle left over from before reset is no false word
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_q <= SETTLE_CNT;
        end else if (settle_q != 2'h0) begin
            settle_q <= settle_q - 2'h1;
        end
    end
    assign settled = (settle_q == 2'h0);

    // Word events; shift data is still while frame sync is high
    assign word_evt = (sy[SY_TGL] ^ tgl_prev_q) && settled;
    assign early_evt = sy[SY_FS] && !fs_prev_q && sy[SY_PART]
        && !cs_prev_n_q && settled;
    assign upd = word_evt || early_evt;
    // No false fall when the pin is held low through reset
    assign latch_update_n_fall = latch_update_n_prev_q && !sy[SY_LATCH_UPDATE_N] && settled;

    // Word fields; a short frame takes the shift register as it stands
    assign new_word = word_evt ? link_word : link_shift;
    assign new_chan = new_word[ADDR_HI_POS:ADDR_LO_POS];
    assign new_pwr = new_word[PWR_POS];
    assign new_spd = new_word[SPD_POS];
    assign new_code = new_word[CODE_MSB:0];

    // Input latches take every word, whatever latch-update does
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                in_code_q[i] <= CODE_RST;
            end
            in_spd_q <= {NUM_CH{SPD_RST}};
            in_pwr_q <= {NUM_CH{PWR_RST}};
        end else if (upd) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (ch_hit(new_chan, 2'(i))) begin
                    in_code_q[i] <= new_code;
                    in_spd_q[i] <= new_spd;
                    in_pwr_q[i] <= new_pwr;
                end
            end
        end
    end

    // With latch-update held low a word drives its channel at once;
    // held high, words wait in the input latches for its falling edge
    always_comb begin
        load_now = '0;
        out_pwr_d = out_pwr_q;
        for (int i = 0; i < NUM_CH; i++) begin
            load_now[i] = upd && ch_hit(new_chan, 2'(i)) && !sy[SY_LATCH_UPDATE_N];
            if (load_now[i]) begin
                out_pwr_d[i] = new_pwr;
            end else if (latch_update_n_fall) begin
                out_pwr_d[i] = in_pwr_q[i];
            end
        end
    end

    // Output latches: a word updates its channel, latch-update all four
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                out_code_q[i] <= CODE_RST;
            end
            out_spd_q <= {NUM_CH{SPD_RST}};
            out_pwr_q <= {NUM_CH{PWR_RST}};
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (load_now[i]) begin
                    out_code_q[i] <= new_code;
                    out_spd_q[i] <= new_spd;
                    out_pwr_q[i] <= new_pwr;
                end else if (latch_update_n_fall) begin
                    out_code_q[i] <= in_code_q[i];
                    out_spd_q[i] <= in_spd_q[i];
                    out_pwr_q[i] <= in_pwr_q[i];
                end
            end
        end
    end

    // Status of the last update
    always_ff @(posedge clk) begin
        if (rst) begin
            update_pulse_q <= 1'b0;
            update_chan_q <= CH_A;
            short_frame_q <= 1'b0;
        end else begin
            update_pulse_q <= upd;
            short_frame_q <= early_evt && !word_evt;
            if (upd) begin
                update_chan_q <= new_chan;
            end
        end
    end

    // Last word taken and running count
    always_ff @(posedge clk) begin
        if (rst) begin
            last_word_q <= WORD_RST;
            word_count_q <= COUNT_RST;
        end else if (upd) begin
            last_word_q <= new_word;
            word_count_q <= word_count_q + 16'h0001;
        end
    end

    // Enables come from the next power state, so they move in the
    // same cycle as the channel latch
    always_ff @(posedge clk) begin
        if (rst) begin
            amp_en_q <= {NUM_CH{1'b0}};
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                amp_en_q[i] <= amp_on(out_pwr_d[i], sy[SY_PD]);
            end
        end
    end

    // Channel outputs
    assign code_a = out_code_q[CH_A];
    assign code_b = out_code_q[CH_B];
    assign code_c = out_code_q[CH_C];
    assign code_d = out_code_q[CH_D];
    assign fast_a = out_spd_q[CH_A];
    assign fast_b = out_spd_q[CH_B];
    assign fast_c = out_spd_q[CH_C];
    assign fast_d = out_spd_q[CH_D];
    assign amp_en_a = amp_en_q[CH_A];
    assign amp_en_b = amp_en_q[CH_B];
    assign amp_en_c = amp_en_q[CH_C];
    assign amp_en_d = amp_en_q[CH_D];

    // Status outputs
    assign update_pulse = update_pulse_q;
    assign update_chan = update_chan_q;
    assign short_frame = short_frame_q;
    assign last_word = last_word_q;
    assign word_count = word_count_q;
endmodule : qdsc_serial_ctrl

// file: tb/qdsc_serial_ctrl_properties.sv
// Assertions on the serial control block outputs.
// Assumes binding to qdsc_serial_ctrl, ports taken by name.
`timescale 1ns/1ns
module qdsc_serial_ctrl_properties
    import qdsc_pkg::*;
(
    // Clock, reset, power pin and latch-update pin
    input wire logic clk, rst, hw_powerdown_n, latch_update_n,
    // Channel outputs
    input wire logic [CODE_BITS-1:0] code_a, code_b, code_d,
    input wire logic amp_en_a, amp_en_b, amp_en_c, amp_en_d,
    // Status
    input wire logic update_pulse, short_frame,
    input wire logic [1:0] update_chan,
    input wire logic [WORD_BITS-1:0] last_word,
    input wire logic [15:0] word_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence pd_high;
        hw_powerdown_n [*4];
    endsequence
    sequence latch_update_n_low;
        !latch_update_n [*4];
    endsequence
    sequence pd_low;
        !hw_powerdown_n [*3];
    endsequence
    a_reset_clear: assert property ($fell(rst) |-> code_a == CODE_RST
        && code_d == CODE_RST && word_count == COUNT_RST)
        else $error("outputs not cleared by reset");
    a_pulse_single: assert property (update_pulse |=> !update_pulse)
        else $error("update pulse too long");
    a_short_update: assert property (short_frame |-> update_pulse)
        else $error("short frame without update");
    a_count_step: assert property (update_pulse |->
        word_count == $past(word_count) + 16'h0001)
        else $error("word count not stepped");
    a_count_hold: assert property (!update_pulse |-> $stable(word_count))
        else $error("word count moved without update");
    a_chan_word: assert property (update_pulse |->
        update_chan == last_word[ADDR_HI_POS:ADDR_LO_POS])
        else $error("update channel differs from word");
    a_word_a_load: assert property (pd_high ##0 latch_update_n_low ##0
        (update_pulse && update_chan == CH_A) |->
        code_a == last_word[CODE_MSB:0]
        && amp_en_a == !last_word[PWR_POS])
        else $error("channel a not loaded from word");
    a_word_d_load: assert property (pd_high ##0 latch_update_n_low ##0
        (update_pulse && update_chan == CH_D) |->
        code_d == last_word[CODE_MSB:0]
        && amp_en_d == !last_word[PWR_POS])
        else $error("channel d not loaded from word");
    a_others_hold: assert property (update_pulse && update_chan != CH_B
        |-> code_b == $past(code_b, 2))
        else $error("channel b changed by other word");
    a_hw_off: assert property (pd_low |=> !amp_en_a && !amp_en_b
        && !amp_en_c && !amp_en_d)
        else $error("amplifier on in hardware power down");
endmodule : qdsc_serial_ctrl_properties

// file: tb/qdsc_host.sv
// Host serial port model: shift clock runs only while a task runs, one tick past each frame.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ns
module qdsc_host (
    // Serial link pins
    output logic sclk, cs_n, frame_sync, sdin
);
    initial {sclk, cs_n, frame_sync, sdin} = 4'he;
    task automatic tick(input int n);
        repeat (n) begin
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
    endtask : tick
    task automatic send(input logic [15:0] w, input int n,
        input logic sel_n, end_n);
        cs_n = sel_n;
        #20 frame_sync = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdin = w[i];
            tick(1);
        end
        #20 frame_sync = 1'b1;
        sdin = ~sdin;
        tick(1);
        cs_n = end_n;
    endtask : send
endmodule : qdsc_host

// file: tb/qdsc_serial_ctrl_tb.sv
// Testbench for the quad converter serial control block.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ns
module qdsc_serial_ctrl_tb;
    import qdsc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic latch_update_n = 1'b0;
    logic hw_powerdown_n = 1'b1;
    logic sclk, cs_n, frame_sync, sdin, update_pulse, short_frame;
    logic fast_a, fast_b, fast_c, fast_d;
    logic amp_en_a, amp_en_b, amp_en_c, amp_en_d;
    logic [CODE_BITS-1:0] code_a, code_b, code_c, code_d;
    logic [1:0] update_chan;
    logic [WORD_BITS-1:0] last_word;
    logic [15:0] word_count;
    logic [13:0] ex [4];
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int upd_cnt = 0;
    int short_cnt = 0;

    initial forever #5 clk = ~clk;
    qdsc_host host (.sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync),
        .sdin(sdin));
    qdsc_serial_ctrl DUT (.*);

    always @(posedge clk) begin
        cycles <= cycles + 1;
        upd_cnt <= upd_cnt + int'(update_pulse === 1'b1);
        short_cnt <= short_cnt + int'(short_frame === 1'b1);
        if (cycles == 6000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [13:0] chan(input int c);
        case (c)
            0: return {amp_en_a, fast_a, code_a};
            1: return {amp_en_b, fast_b, code_b};
            2: return {amp_en_c, fast_c, code_c};
            default: return {amp_en_d, fast_d, code_d};
        endcase
    endfunction : chan

    task automatic chk_all();
        for (int c = 0; c < NUM_CH; c++)
            chk("channel", 16'(chan(c)), 16'(ex[c]));
    endtask : chk_all

    // One frame, then the count of updates it caused
    task automatic wr(input logic [15:0] w, input int n, nu,
        input logic sel_n, end_n);
        int u;
        u = upd_cnt;
        host.send(w, n, sel_n, end_n);
        repeat (4) @(posedge clk);
        chk("updates", 16'(upd_cnt - u), 16'(nu));
    endtask : wr

    task automatic t_reset();
        for (int c = 0; c < NUM_CH; c++) ex[c] = {1'b1, SPD_RST, CODE_RST};
        chk_all();
        chk("count", word_count, COUNT_RST);
    endtask : t_reset

    task automatic t_words();
        logic [15:0] w [4] = '{16'h1fff, 16'h6000, 16'h8abc, 16'hd800};
        for (int i = 0; i < 4; i++) begin
            wr(w[i], 16, 1, 1'b0, i < 2);
            ex[w[i][15:14]] = {~w[i][PWR_POS], w[i][SPD_POS], w[i][11:0]};
            chk_all();
            chk("word", last_word, w[i]);
        end
    endtask : t_words

    task automatic t_ignore();
        wr(16'h1123, 16, 0, 1'b1, 1'b1);
        chk_all();
    endtask : t_ignore

    task automatic t_short();
        int s;
        s = short_cnt;
        wr(16'hab00, 8, 1, 1'b0, 1'b1);
        ex[0] = {1'b1, 1'b0, 12'h0ab};
        chk_all();
        chk("short", 16'(short_cnt - s), 16'h0001);
    endtask : t_short

    task automatic t_hwpd();
        hw_powerdown_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("amp", 16'({amp_en_a, amp_en_b, amp_en_c, amp_en_d}),
            16'h0000);
        hw_powerdown_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk_all();
    endtask : t_hwpd

    task automatic t_latch();
        latch_update_n <= 1'b1;
        repeat (5) @(posedge clk);
        wr(16'h4321, 16, 1, 1'b0, 1'b0);
        chk_all();
        latch_update_n <= 1'b0;
        repeat (6) @(posedge clk);
        ex[1] = {1'b1, 1'b0, 12'h321};
        chk_all();
    endtask : t_latch

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial begin
        fork
            host.tick(4);
            repeat (12) @(posedge clk);
        join
        @(posedge clk);
        rst <= 1'b0;
        host.tick(3);
        @(posedge clk);
        t_reset();
        t_words();
        t_ignore();
        t_short();
        t_hwpd();
        t_latch();
        wrap_up();
    end
endmodule : qdsc_serial_ctrl_tb

bind qdsc_serial_ctrl qdsc_serial_ctrl_properties u_props (.*);
